// >>> include/qdc_pkg.sv
// Shared types and constants of the queued DMA command-layer sequencer.
// Assumes one core clock domain and a transport layer that acknowledges frames.
package qdc_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] QDC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] QDC_OFS_STATUS  = 8'h04;
  localparam logic [7:0] QDC_OFS_PENDING = 8'h08;
  localparam logic [7:0] QDC_OFS_DONE    = 8'h0C;

  // Control register fields.
  localparam int QDC_CTRL_AA_EN_BIT  = 0;
  localparam int QDC_CTRL_REL_IE_BIT = 1;
  localparam int QDC_CTRL_NZOFS_BIT  = 2;
  localparam int QDC_CTRL_W          = 3;
  localparam logic [2:0] QDC_CTRL_RST = 3'h0;

  // Status register fields.
  localparam int QDC_STAT_STATE_LSB = 0;
  localparam int QDC_STAT_HALT_BIT  = 8;
  localparam int QDC_STAT_OFSV_BIT  = 9;

  localparam logic [1:0] QDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] QDC_RESP_SLVERR = 2'h2;

  // Error field value sent by the broken-host state (command abort).
  localparam logic [7:0] QDC_ERR_ABORT = 8'h04;

  typedef enum logic [1:0] {
    QDC_REG_CTRL, QDC_REG_STATUS, QDC_REG_PENDING, QDC_REG_DONE
  } qdc_reg_t;

  typedef enum logic [2:0] {
    QDC_FR_REG_D2H, QDC_FR_DMA_ACT, QDC_FR_DMA_SETUP, QDC_FR_DATA, QDC_FR_SDB
  } qdc_frame_kind_t;

  typedef enum logic [1:0] {
    QDC_CMD_LEGACY_WR, QDC_CMD_NATIVE, QDC_CMD_LOG_READ, QDC_CMD_OTHER
  } qdc_cmd_kind_t;

  typedef enum {
    QDC_IDLE, QUEUED_WRITE_ENTRY_STATE, QDC_LQ_ACT, QDC_LQ_RX, QDC_LQ_PREP,
    QDC_LQ_STATUS, QDC_LQ_RELEASE, ENQUEUE_STATE, QDC_NQ_CLRBUSY,
    QDC_NQ_RDSETUP, QDC_NQ_PREWR, QDC_NQ_WRSETUP_AA, QDC_NQ_WRSETUP_OLD,
    QDC_NQ_ACT, QDC_NQ_XMITRD, QDC_NQ_XMITWR, QDC_NQ_STATUS, QDC_NQ_ERROR,
    BROKEN_HOST_STATE, ERROR_CLEARING_WAIT_STATE
  } qdc_state_t;

  typedef struct packed {
    qdc_frame_kind_t kind;
    logic            intr;
    logic            bus_release_flag;
    logic            err;
    logic            interface_busy_bit;
    logic            data_request_bit;
    logic            dir_d2h;
    logic            auto_act;
    logic [4:0]      buf_id;
    logic [31:0]     active_tag_field;
    logic [7:0]      err_code;
  } qdc_frame_t;

  typedef struct packed {
    qdc_cmd_kind_t kind;
    logic [4:0]    tag;
    logic          malformed;
  } qdc_cmd_t;

  // Conditions reported by the device core.
  typedef struct packed {
    logic       rx_ready;
    logic       abort;
    logic       all_done;
    logic       xfer_exhausted;
    logic       cmd_complete;
    logic       unrec_err;
    logic [7:0] err_code;
  } qdc_core_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } qdc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } qdc_axi_rsp_t;

endpackage

// >>> verilog/qdc_seq.sv
// Queued DMA command-layer sequencer: legacy queued write and native queued machines.
// Assumes the transport layer holds tx_done for one cycle per finished frame request,
// and that core conditions are valid in the cycle the machine consults them.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module qdc_seq
  import qdc_pkg::*;
#(
  parameter int  QDEPTH       = 32,
  parameter bit  AA_SUPPORTED = 1'b1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         cmd_valid,
  input  qdc_cmd_t          cmd,
  output logic              cmd_ready_r,
  input  wire logic         dp_valid,
  input  wire logic [4:0]   dp_tag,
  input  wire logic         dp_write,
  output logic              dp_ready_r,
  input  wire logic         tag_done_valid,
  input  wire logic [4:0]   tag_done,
  input  wire logic         nq_err,
  input  wire logic         software_reset_request,
  input  qdc_core_t         core,
  output logic              tx_req_r,
  output qdc_frame_t        tx_frame_r,
  input  wire logic         tx_done,
  input  wire logic         rx_done,
  input  qdc_axi_req_t      axi_req,
  output qdc_axi_rsp_t      axi_rsp_r
);

  typedef struct packed {
    qdc_state_t   state;
    logic         tx_req;
    qdc_frame_t   frame;
    logic [4:0]   cur_tag;
    logic         cmd_bad;
    logic [31:0]  pending;
    logic [31:0]  done;
    logic         halted;
    logic         err_pend;
    logic         ofs_viol;
    logic         cmd_ready;
    logic         dp_ready;
    logic [2:0]   ctrl;
    logic         aw_have;
    logic [7:0]   aw_addr;
    logic         w_have;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    qdc_axi_rsp_t axi;
  } qdc_regs_t;

  qdc_regs_t s_r;
  qdc_regs_t s_nxt;

  // The tag bitmaps are 32 bits wide, so a deeper queue cannot be tracked.
  if (QDEPTH < 1 || QDEPTH > 32) begin : g_bad_depth
    $error("qdc_seq: QDEPTH must lie in 1..32");
  end

  function automatic logic reg_hit(input logic [7:0] addr, output qdc_reg_t sel);
    sel = QDC_REG_CTRL;
    reg_hit = 1'b1;
    case (addr)
      QDC_OFS_CTRL: begin
        sel = QDC_REG_CTRL;
      end
      QDC_OFS_STATUS: begin
        sel = QDC_REG_STATUS;
      end
      QDC_OFS_PENDING: begin
        sel = QDC_REG_PENDING;
      end
      QDC_OFS_DONE: begin
        sel = QDC_REG_DONE;
      end
      default: begin
        reg_hit = 1'b0;
      end
    endcase
  endfunction

  function automatic qdc_frame_t mk_frame(input qdc_frame_kind_t kind);
    mk_frame = '0;
    mk_frame.kind = kind;
  endfunction

  logic tag_ok;
  // The captured tag is checked, so a host that changes cmd after the take cannot mislead it.
  assign tag_ok = (32'(s_r.cur_tag) < 32'(QDEPTH)) && !s_r.pending[s_r.cur_tag];

  always_comb begin
    qdc_frame_t    f;
    qdc_state_t    nxt;
    logic          send;
    logic          fin;
    logic          clear_q;
    logic [31:0]   reported;
    qdc_reg_t      sel;
    logic          hit;
    logic          ofs_set;
    f = '0;
    ofs_set = 1'b0;
    nxt = QDC_IDLE;
    send = 1'b0;
    clear_q = 1'b0;
    reported = '0;
    sel = QDC_REG_CTRL;
    hit = 1'b0;
    s_nxt = s_r;
    fin = s_r.tx_req && tx_done;

    // A late error indication is remembered until the idle state acts on it; leaving the error-clearing wait drops it.
    if (nq_err) begin
      s_nxt.err_pend = 1'b1;
    end

    case (s_r.state)
      QDC_IDLE: begin
        if (s_r.err_pend && !s_r.halted) begin
          s_nxt.err_pend = nq_err;
          s_nxt.state = QDC_NQ_ERROR;
        end else if (cmd_valid && s_r.cmd_ready) begin
          s_nxt.cur_tag = cmd.tag;
          s_nxt.cmd_bad = cmd.malformed;
          if (cmd.kind == QDC_CMD_LEGACY_WR) begin
            s_nxt.state = QUEUED_WRITE_ENTRY_STATE;
          end else if (cmd.kind == QDC_CMD_NATIVE) begin
            s_nxt.state = ENQUEUE_STATE;
          end
        end else if (s_r.done != '0 && !s_r.halted) begin
          s_nxt.state = QDC_NQ_STATUS;
        end else if (dp_valid && s_r.dp_ready) begin
          s_nxt.cur_tag = dp_tag;
          s_nxt.state = dp_write ? QDC_NQ_PREWR : QDC_NQ_RDSETUP;
        end
      end
      QUEUED_WRITE_ENTRY_STATE: begin
        if (core.abort) begin
          s_nxt.state = QDC_LQ_STATUS;
        end else if (core.rx_ready) begin
          s_nxt.state = QDC_LQ_ACT;
        end else begin
          s_nxt.state = QDC_LQ_RELEASE;
        end
      end
      QDC_LQ_ACT: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DMA_ACT);
        nxt = QDC_LQ_RX;
      end
      QDC_LQ_RX: begin
        if (rx_done) begin
          s_nxt.state = QDC_LQ_PREP;
        end
      end
      QDC_LQ_PREP: begin
        if (core.abort || core.all_done) begin
          s_nxt.state = QDC_LQ_STATUS;
        end else if (core.rx_ready) begin
          s_nxt.state = QDC_LQ_ACT;
        end
      end
      QDC_LQ_STATUS: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_REG_D2H);
        f.intr = 1'b1;
        f.err = core.abort;
        f.err_code = core.err_code;
        nxt = QDC_IDLE;
      end
      QDC_LQ_RELEASE: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_REG_D2H);
        f.bus_release_flag = 1'b1;
        f.intr = s_r.ctrl[QDC_CTRL_REL_IE_BIT];
        nxt = QDC_IDLE;
      end
      ENQUEUE_STATE: begin
        if (s_r.cmd_bad || !tag_ok) begin
          s_nxt.state = BROKEN_HOST_STATE;
        end else begin
          s_nxt.pending[s_r.cur_tag] = 1'b1;
          s_nxt.state = QDC_NQ_CLRBUSY;
        end
      end
      QDC_NQ_CLRBUSY: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_REG_D2H);
        nxt = QDC_IDLE;
      end
      QDC_NQ_RDSETUP: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DMA_SETUP);
        f.buf_id = s_r.cur_tag;
        f.dir_d2h = 1'b1;
        nxt = QDC_NQ_XMITRD;
      end
      QDC_NQ_PREWR: begin
        if (AA_SUPPORTED && s_r.ctrl[QDC_CTRL_AA_EN_BIT]) begin
          s_nxt.state = QDC_NQ_WRSETUP_AA;
        end else begin
          s_nxt.state = QDC_NQ_WRSETUP_OLD;
        end
      end
      QDC_NQ_WRSETUP_AA: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DMA_SETUP);
        f.buf_id = s_r.cur_tag;
        f.auto_act = 1'b1;
        nxt = QDC_NQ_XMITWR;
      end
      QDC_NQ_WRSETUP_OLD: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DMA_SETUP);
        f.buf_id = s_r.cur_tag;
        nxt = QDC_NQ_ACT;
      end
      QDC_NQ_ACT: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DMA_ACT);
        nxt = QDC_NQ_XMITWR;
      end
      QDC_NQ_XMITRD: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_DATA);
        f.buf_id = s_r.cur_tag;
        nxt = QDC_NQ_XMITRD;
        if (core.unrec_err || core.cmd_complete || core.xfer_exhausted) begin
          nxt = QDC_IDLE;
        end
        // A partial return without offset support is still honoured but flagged.
        if (fin && core.xfer_exhausted && !core.cmd_complete && !core.unrec_err &&
            !s_r.ctrl[QDC_CTRL_NZOFS_BIT]) begin
          s_nxt.ofs_viol = 1'b1;
          ofs_set = 1'b1;
        end
      end
      QDC_NQ_XMITWR: begin
        if (rx_done) begin
          if (core.unrec_err || core.cmd_complete || core.xfer_exhausted) begin
            s_nxt.state = QDC_IDLE;
            if (core.xfer_exhausted && !core.cmd_complete && !core.unrec_err &&
                !s_r.ctrl[QDC_CTRL_NZOFS_BIT]) begin
              s_nxt.ofs_viol = 1'b1;
              ofs_set = 1'b1;
            end
          end else begin
            s_nxt.state = QDC_NQ_ACT;
          end
        end
      end
      QDC_NQ_STATUS: begin
        send = 1'b1;
        f = mk_frame(QDC_FR_SDB);
        f.intr = 1'b1;
        f.active_tag_field = s_r.done;
        nxt = QDC_IDLE;
        if (fin) begin
          reported = s_r.frame.active_tag_field;
        end
      end
      QDC_NQ_ERROR: begin
        send = 1'b1;
        s_nxt.halted = 1'b1;
        f = mk_frame(QDC_FR_SDB);
        f.intr = 1'b1;
        f.err = 1'b1;
        f.err_code = core.err_code;
        f.active_tag_field = s_r.done;
        nxt = ERROR_CLEARING_WAIT_STATE;
        if (fin) begin
          reported = s_r.frame.active_tag_field;
        end
      end
      BROKEN_HOST_STATE: begin
        send = 1'b1;
        s_nxt.halted = 1'b1;
        f = mk_frame(QDC_FR_REG_D2H);
        f.err = 1'b1;
        f.intr = 1'b1;
        f.err_code = QDC_ERR_ABORT;
        nxt = ERROR_CLEARING_WAIT_STATE;
      end
      ERROR_CLEARING_WAIT_STATE: begin
        if (software_reset_request) begin
          clear_q = 1'b1;
        end else if (cmd_valid && s_r.cmd_ready) begin
          if (cmd.kind == QDC_CMD_LOG_READ) begin
            clear_q = 1'b1;
          end else begin
            s_nxt.state = BROKEN_HOST_STATE;
          end
        end
        if (clear_q) begin
          s_nxt.state = QDC_IDLE;
          s_nxt.halted = 1'b0;
          s_nxt.err_pend = nq_err;
        end
      end
      default: begin
        s_nxt.state = QDC_IDLE;
      end
    endcase

    // The request and its frame stay frozen until the transport layer answers.
    if (send) begin
      if (!s_r.tx_req) begin
        s_nxt.tx_req = 1'b1;
        s_nxt.frame = f;
      end else if (tx_done) begin
        s_nxt.tx_req = 1'b0;
        s_nxt.state = nxt;
      end
    end

    // Reported tags leave the queue; a completion in the same cycle still lands.
    s_nxt.pending = s_nxt.pending & ~reported;
    s_nxt.done = s_r.done & ~reported;
    if (clear_q) begin
      s_nxt.pending = '0;
      s_nxt.done = '0;
    end
    if (tag_done_valid && s_r.pending[tag_done]) begin
      s_nxt.done[tag_done] = 1'b1;
    end

    // Command ready is shown when idle with no error pending or in the error-clearing wait;
    // a software reset there drops an offered command, and in idle a command beats a data phase.
    s_nxt.cmd_ready = ((s_nxt.state == QDC_IDLE) && !s_nxt.err_pend) ||
                      (s_nxt.state == ERROR_CLEARING_WAIT_STATE);
    s_nxt.dp_ready = (s_nxt.state == QDC_IDLE) && !s_nxt.halted && !s_nxt.err_pend &&
                     (s_nxt.done == '0);

    // AXI4-Lite slave: address and data are taken in either order.
    if (axi_req.awvalid && s_r.axi.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_r.axi.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    if (s_r.axi.bvalid && axi_req.bready) begin
      s_nxt.axi.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.axi.bvalid) begin
      hit = reg_hit(s_r.aw_addr, sel);
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.axi.bvalid = 1'b1;
      s_nxt.axi.bresp = hit ? QDC_RESP_OKAY : QDC_RESP_SLVERR;
      if (hit && sel == QDC_REG_CTRL && s_r.w_strb[0]) begin
        s_nxt.ctrl = s_r.w_data[QDC_CTRL_W-1:0];
      end
      // Write one clears the offset flag unless it is raised in the same cycle.
      if (hit && sel == QDC_REG_STATUS && s_r.w_strb[1] &&
          s_r.w_data[QDC_STAT_OFSV_BIT] && !ofs_set) begin
        s_nxt.ofs_viol = 1'b0;
      end
    end
    s_nxt.axi.awready = !s_nxt.aw_have;
    s_nxt.axi.wready = !s_nxt.w_have;

    if (s_r.axi.rvalid && axi_req.rready) begin
      s_nxt.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_r.axi.arready) begin
      hit = reg_hit(axi_req.araddr, sel);
      s_nxt.axi.rvalid = 1'b1;
      s_nxt.axi.rresp = hit ? QDC_RESP_OKAY : QDC_RESP_SLVERR;
      s_nxt.axi.rdata = '0;
      if (hit) begin
        case (sel)
          QDC_REG_CTRL: begin
            s_nxt.axi.rdata[QDC_CTRL_W-1:0] = s_r.ctrl;
          end
          QDC_REG_STATUS: begin
            s_nxt.axi.rdata[QDC_STAT_STATE_LSB +: 5] = 5'(s_r.state);
            s_nxt.axi.rdata[QDC_STAT_HALT_BIT] = s_r.halted;
            s_nxt.axi.rdata[QDC_STAT_OFSV_BIT] = s_r.ofs_viol;
          end
          QDC_REG_PENDING: begin
            s_nxt.axi.rdata = s_r.pending;
          end
          QDC_REG_DONE: begin
            s_nxt.axi.rdata = s_r.done;
          end
          default: begin
            s_nxt.axi.rdata = '0;
          end
        endcase
      end
    end
    s_nxt.axi.arready = !s_nxt.axi.rvalid;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= QDC_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready_r = s_r.cmd_ready;
  assign dp_ready_r  = s_r.dp_ready;
  assign tx_req_r    = s_r.tx_req;
  assign tx_frame_r  = s_r.frame;
  assign axi_rsp_r   = s_r.axi;

endmodule

// >>> tb/qdc_seq_monitor.sv
// Checker for the queued DMA sequencer: frame requests and command taking.
// Assumes one clock domain with an active high asynchronous reset.
`timescale 1ns/100ps
module qdc_seq_monitor
  import qdc_pkg::*;
#(
  parameter int QDEPTH       = 32,
  parameter bit AA_SUPPORTED = 1'b1
) (
  input wire logic  sys_clk,
  input wire logic  reset,
  input wire logic  cmd_valid,
  input qdc_cmd_t   cmd,
  input wire logic  cmd_ready_r,
  input wire logic  tx_req_r,
  input qdc_frame_t tx_frame_r,
  input wire logic  tx_done
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);
  qdc_frame_t f;
  logic       sent;
  assign f = tx_frame_r;
  assign sent = tx_req_r && tx_done;
  property p_hold;
    tx_req_r && !tx_done |=> tx_req_r && $stable(f);
  endproperty
  a_hold: assert property (p_hold) else $error("frame changed before ack");
  property p_drop;
    sent |=> !tx_req_r;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_setup_intr;
    tx_req_r && f.kind == QDC_FR_DMA_SETUP |-> !f.intr;
  endproperty
  a_setup_intr: assert property (p_setup_intr) else $error("bad setup");
  property p_aa;
    tx_req_r && f.kind == QDC_FR_DMA_SETUP && f.auto_act |-> AA_SUPPORTED && !f.dir_d2h;
  endproperty
  a_aa: assert property (p_aa) else $error("bad auto-activate setup");
  property p_sdb;
    tx_req_r && f.kind == QDC_FR_SDB |-> f.intr;
  endproperty
  a_sdb: assert property (p_sdb) else $error("status bits without interrupt");
  property p_clr;
    tx_req_r && f.kind == QDC_FR_REG_D2H && !f.intr && !f.bus_release_flag
      |-> !f.data_request_bit && !f.interface_busy_bit && !f.err;
  endproperty
  a_clr: assert property (p_clr) else $error("busy clear frame wrong");
  property p_enq;
    cmd_valid && cmd_ready_r && cmd.kind == QDC_CMD_NATIVE
      |=> !cmd_ready_r ##[1:4] tx_req_r && f.kind == QDC_FR_REG_D2H;
  endproperty
  a_enq: assert property (p_enq) else $error("no frame after queued command");
  property p_plain;
    sent && f.kind == QDC_FR_DMA_SETUP && !f.dir_d2h && !f.auto_act
      |-> ##[1:3] tx_req_r && f.kind == QDC_FR_DMA_ACT;
  endproperty
  a_plain: assert property (p_plain) else $error("no activate after setup");
  property p_rd;
    sent && f.kind == QDC_FR_DMA_SETUP && f.dir_d2h |-> ##[1:3] tx_req_r && f.kind == QDC_FR_DATA;
  endproperty
  a_rd: assert property (p_rd) else $error("no data after read setup");
  property p_aa_rx;
    sent && f.kind == QDC_FR_DMA_SETUP && f.auto_act |=> !tx_req_r [*2];
  endproperty
  a_aa_rx: assert property (p_aa_rx) else $error("frame sent before write data");
  c_err: cover property (tx_req_r && f.kind == QDC_FR_SDB && f.err);
  c_rel: cover property (tx_req_r && f.bus_release_flag && f.intr);
  c_aa: cover property (tx_req_r && f.kind == QDC_FR_DMA_SETUP && f.auto_act);
endmodule
bind qdc_seq qdc_seq_monitor #(.QDEPTH(QDEPTH), .AA_SUPPORTED(AA_SUPPORTED)) qdc_seq_monitor_i (
  .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready_r(cmd_ready_r), .tx_req_r(tx_req_r), .tx_frame_r(tx_frame_r), .tx_done(tx_done));

// >>> tb/qdc_host_model.sv
// Host and transport stand-in: acknowledges each frame and returns write data frames.
// Assumes one sequencer; slow stretches every acknowledgement by four cycles.
`timescale 1ns/100ps
module qdc_host_model
  import qdc_pkg::*;
(
  input wire logic  sys_clk,
  input wire logic  reset,
  input wire logic  slow,
  input wire logic  tx_req_r,
  input qdc_frame_t tx_frame_r,
  output logic      tx_done,
  output logic      rx_done
);
  logic [2:0] ack_cnt;
  logic [2:0] rx_cnt;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_cnt <= 3'h0;
      rx_cnt <= 3'h0;
      tx_done <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      rx_done <= (rx_cnt == 3'h1);
      if (rx_cnt != 3'h0)
        rx_cnt <= rx_cnt - 3'h1;
      if (tx_req_r && !tx_done) begin
        ack_cnt <= ack_cnt + 3'h1;
        if (ack_cnt >= (slow ? 3'h4 : 3'h0)) begin
          tx_done <= 1'b1;
          ack_cnt <= 3'h0;
          // Host data follows an activate or an auto-activating write setup.
          if (tx_frame_r.kind == QDC_FR_DMA_ACT || (tx_frame_r.kind == QDC_FR_DMA_SETUP
              && tx_frame_r.auto_act && !tx_frame_r.dir_d2h))
            rx_cnt <= 3'h3;
        end
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Testbench of the queued DMA sequencer: bus tasks, command tasks and frame checks.
// Assumes the host model acknowledges frames; registers are reached over AXI4-Lite.
`timescale 1ns/100ps
module tb_top;
  import qdc_pkg::*;
  logic         sys_clk, reset, slow, cmd_valid, cmd_ready_r, dp_valid, dp_write, dp_ready_r;
  logic         tag_done_valid, nq_err, software_reset_request, tx_req_r, tx_done, rx_done;
  logic [4:0]   dp_tag, tag_done;
  qdc_cmd_t     cmd;
  qdc_core_t    core;
  qdc_frame_t   tx_frame_r, fr;
  qdc_axi_req_t axi_req;
  qdc_axi_rsp_t axi_rsp_r;
  int           err_total, total_checks, i;
  qdc_seq qdc_seq_i (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready_r(cmd_ready_r), .dp_valid(dp_valid), .dp_tag(dp_tag), .dp_write(dp_write),
    .dp_ready_r(dp_ready_r), .tag_done_valid(tag_done_valid), .tag_done(tag_done),
    .nq_err(nq_err), .software_reset_request(software_reset_request), .core(core),
    .tx_req_r(tx_req_r), .tx_frame_r(tx_frame_r), .tx_done(tx_done), .rx_done(rx_done),
    .axi_req(axi_req), .axi_rsp_r(axi_rsp_r));
  qdc_host_model qdc_host_model_i (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .tx_req_r(tx_req_r), .tx_frame_r(tx_frame_r), .tx_done(tx_done), .rx_done(rx_done));
  always #2.5 sys_clk = ~sys_clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 300) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic acc(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    axi_req <= '{awvalid: wr, awaddr: a, wvalid: wr, wdata: d, wstrb: 4'hF, bready: wr,
                 arvalid: !wr, araddr: a, rready: !wr};
    for (n = 0; n < 300; n++) begin
      @(posedge sys_clk);
      if (axi_rsp_r.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp_r.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp_r.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp_r.bvalid || axi_rsp_r.rvalid) break;
    end
    axi_req.bready <= 1'b0;
    axi_req.rready <= 1'b0;
    lim(n);
    chk(32'(wr ? axi_rsp_r.bresp : axi_rsp_r.rresp), 32'(er));
    if (!wr)
      chk(axi_rsp_r.rdata, d);
  endtask
  // Offers a command, or a data phase when dp is set; b is malformed or write.
  task automatic req(input bit dp, input qdc_cmd_kind_t k, input logic [4:0] t,
                     input logic b);
    int n;
    @(posedge sys_clk);
    cmd_valid <= !dp;
    dp_valid <= dp;
    cmd <= '{kind: k, tag: t, malformed: b};
    dp_tag <= t;
    dp_write <= b;
    for (n = 0; n < 300; n++) begin
      @(posedge sys_clk);
      if (dp ? dp_ready_r : cmd_ready_r) break;
    end
    cmd_valid <= 1'b0;
    dp_valid <= 1'b0;
    lim(n);
  endtask
  task automatic frame(input qdc_frame_kind_t k);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge sys_clk);
      if (tx_req_r && tx_done) break;
    end
    lim(n);
    fr = tx_frame_r;
    chk(32'(fr.kind), 32'(k));
  endtask
  task automatic finish_tag(input logic [4:0] t, input logic e);
    @(posedge sys_clk);
    tag_done_valid <= 1'b1;
    tag_done <= t;
    nq_err <= e;
    @(posedge sys_clk);
    tag_done_valid <= 1'b0;
    nq_err <= 1'b0;
  endtask
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {slow, cmd_valid, dp_valid, dp_write, tag_done_valid, nq_err} <= 6'h0;
    {software_reset_request, dp_tag, tag_done} <= 11'h0;
    {cmd, core, axi_req} <= '0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    acc(0, QDC_OFS_CTRL, 32'h0, QDC_RESP_OKAY);
    acc(0, 8'h10, 32'h0, QDC_RESP_SLVERR);
    acc(1, 8'h10, 32'h7, QDC_RESP_SLVERR);
    acc(0, QDC_OFS_PENDING, 32'h0, QDC_RESP_OKAY);
    $display("registers done");
    core.rx_ready <= 1'b1;
    req(0, QDC_CMD_LEGACY_WR, 5'h0, 1'b0);
    frame(QDC_FR_DMA_ACT);
    frame(QDC_FR_DMA_ACT);
    core.rx_ready <= 1'b0;
    core.all_done <= 1'b1;
    frame(QDC_FR_REG_D2H);
    chk(32'({fr.intr, fr.bus_release_flag}), 32'h2);
    core.all_done <= 1'b0;
    for (i = 0; i < 2; i++) begin
      acc(1, QDC_OFS_CTRL, 32'(i << 1), QDC_RESP_OKAY);
      req(0, QDC_CMD_LEGACY_WR, 5'h0, 1'b0);
      frame(QDC_FR_REG_D2H);
      chk(32'({fr.bus_release_flag, fr.intr}), 32'(2 + i));
    end
    core.abort <= 1'b1;
    core.err_code <= 8'h51;
    req(0, QDC_CMD_LEGACY_WR, 5'h0, 1'b0);
    frame(QDC_FR_REG_D2H);
    chk(32'({fr.err, fr.intr, fr.err_code}), 32'h351);
    core.abort <= 1'b0;
    $display("legacy done");
    req(0, QDC_CMD_NATIVE, 5'h3, 1'b0);
    frame(QDC_FR_REG_D2H);
    chk(32'({fr.intr, fr.data_request_bit, fr.interface_busy_bit}), 32'h0);
    acc(0, QDC_OFS_PENDING, 32'h8, QDC_RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      req(0, QDC_CMD_NATIVE, 5'h3, 1'(i));
      frame(QDC_FR_REG_D2H);
      chk(32'({fr.err, fr.intr, fr.interface_busy_bit, fr.data_request_bit}), 32'hC);
      chk(32'(fr.err_code), 32'(QDC_ERR_ABORT));
      req(0, QDC_CMD_LOG_READ, 5'h0, 1'b0);
      acc(0, QDC_OFS_PENDING, 32'h0, QDC_RESP_OKAY);
    end
    $display("enqueue done");
    slow <= 1'b1;
    req(0, QDC_CMD_NATIVE, 5'h5, 1'b0);
    frame(QDC_FR_REG_D2H);
    req(1, QDC_CMD_OTHER, 5'h5, 1'b0);
    frame(QDC_FR_DMA_SETUP);
    chk(32'({fr.dir_d2h, fr.auto_act, fr.intr, fr.buf_id}), 32'h85);
    frame(QDC_FR_DATA);
    repeat (3) @(posedge sys_clk);
    core.cmd_complete <= 1'b1;
    frame(QDC_FR_DATA);
    finish_tag(5'h5, 1'b0);
    frame(QDC_FR_SDB);
    chk(fr.active_tag_field, 32'h20);
    acc(0, QDC_OFS_PENDING, 32'h0, QDC_RESP_OKAY);
    $display("read phase done");
    for (i = 0; i < 2; i++) begin
      acc(1, QDC_OFS_CTRL, 32'(1 - i), QDC_RESP_OKAY);
      req(0, QDC_CMD_NATIVE, 5'(7 + i), 1'b0);
      core.cmd_complete <= 1'b0;
      frame(QDC_FR_REG_D2H);
      req(1, QDC_CMD_OTHER, 5'(7 + i), 1'b1);
      frame(QDC_FR_DMA_SETUP);
      chk(32'({fr.dir_d2h, fr.auto_act, fr.buf_id}), 32'(((1 - i) << 5) | (7 + i)));
      if (i == 1)
        frame(QDC_FR_DMA_ACT);
      frame(QDC_FR_DMA_ACT);
      core.cmd_complete <= 1'b1;
    end
    $display("write phase done");
    finish_tag(5'h7, 1'b1);
    frame(QDC_FR_SDB);
    chk(32'({fr.err, fr.intr}), 32'h3);
    chk(fr.active_tag_field, 32'h80);
    @(posedge sys_clk);
    software_reset_request <= 1'b1;
    @(posedge sys_clk);
    software_reset_request <= 1'b0;
    acc(0, QDC_OFS_PENDING, 32'h0, QDC_RESP_OKAY);
    $display("error done");
    core <= '{xfer_exhausted: 1'b1, default: '0};
    req(0, QDC_CMD_NATIVE, 5'h9, 1'b0);
    frame(QDC_FR_REG_D2H);
    req(1, QDC_CMD_OTHER, 5'h9, 1'b0);
    frame(QDC_FR_DMA_SETUP);
    frame(QDC_FR_DATA);
    acc(0, QDC_OFS_STATUS, 32'h1 << QDC_STAT_OFSV_BIT, QDC_RESP_OKAY);
    acc(1, QDC_OFS_STATUS, 32'h1 << QDC_STAT_OFSV_BIT, QDC_RESP_OKAY);
    acc(0, QDC_OFS_STATUS, 32'h0, QDC_RESP_OKAY);
    $display("offset flag done");
    give_verdict();
  end
endmodule
